// *** core/qpc_pkg.sv ***
// Purpose: shared constants for the quadrature position counter
// Assumes: 32-bit Avalon-MM register slave, word addressed by byte offset
// Notes: register map offsets are byte addresses
package qpc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] QPC_OFF_CTRL = 4'h0;
  localparam logic [3:0] QPC_OFF_FILT = 4'h4;
  localparam logic [3:0] QPC_OFF_POS = 4'h8;
  localparam logic [3:0] QPC_OFF_MAX = 4'hc;
  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int QPC_CTRL_ERR_BIT = 15;
  localparam int QPC_CTRL_DIR_BIT = 11;
  localparam int QPC_CTRL_MODE_LO = 8;
  localparam int QPC_CTRL_IDXRST_BIT = 2;
  localparam int QPC_CTRL_IDXIRQ_BIT = 1;
  localparam int QPC_CTRL_IDXMSK_BIT = 0;
  // ****************************************************************
  // filter control register fields
  // ****************************************************************
  localparam int QPC_FILT_COUNT_ERROR_INTERRUPT_DISABLE_BIT = 8;
  localparam int QPC_FILT_IMV_LO = 9;
  // ****************************************************************
  // mode encodings and reset values
  // ****************************************************************
  localparam logic [2:0] QPC_MODE_OFF = 3'h0;
  localparam logic [2:0] QPC_MODE_X2_IDX = 3'h4;
  localparam logic [2:0] QPC_MODE_X2_MAX = 3'h5;
  localparam logic [2:0] QPC_MODE_X4_IDX = 3'h6;
  localparam logic [2:0] QPC_MODE_X4_MAX = 3'h7;
  localparam logic [15:0] QPC_POS_RST = 16'h0000;
  localparam logic [15:0] QPC_MAX_RST = 16'hffff;
  localparam logic [15:0] QPC_ERR_CMP = 16'hffff;
endpackage

// *** core/qpc_enc_if.sv ***
// Purpose: carries decoded encoder events from the decoder to the counter
// Assumes: single clock domain
// Notes: pulses last one cycle
`timescale 1ns/1ps
`default_nettype none
interface qpc_enc_if;
  logic cnt_pulse;
  logic up;
  logic a_lvl;
  logic b_lvl;
  logic idx_lvl;
  modport dec (output cnt_pulse, output up, output a_lvl, output b_lvl, output idx_lvl);
  modport cnt (input cnt_pulse, input up, input a_lvl, input b_lvl, input idx_lvl);
endinterface
`default_nettype wire

// *** core/qpc_decoder.sv ***
// Purpose: synchronise encoder pins and produce count pulses and direction
// Assumes: encoder pins are asynchronous to ref_clk
// Notes: three stages; a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module qpc_decoder
  import qpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_pulse_input,
  input wire logic x4_mode,
  qpc_enc_if.dec enc
);
  logic [2:0] a_sync_ff, b_sync_ff, i_sync_ff;
  logic a_ff, b_ff, i_ff;
  logic up_ff;
  logic pulse_ff;
  logic nxt_a, nxt_b, a_chg, b_chg;

  // ****************************************************************
  // synchroniser
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      a_sync_ff <= 3'h0;
      b_sync_ff <= 3'h0;
      i_sync_ff <= 3'h0;
    end else begin
      a_sync_ff <= {a_sync_ff[1:0], phase_a_input};
      b_sync_ff <= {b_sync_ff[1:0], phase_b_input};
      i_sync_ff <= {i_sync_ff[1:0], index_pulse_input};
    end
  end

  // glitch reject: only take a level once stages two and three agree
  always_comb begin
    nxt_a = (a_sync_ff[1] == a_sync_ff[2]) ? a_sync_ff[2] : a_ff;
    nxt_b = (b_sync_ff[1] == b_sync_ff[2]) ? b_sync_ff[2] : b_ff;
    a_chg = nxt_a != a_ff;
    b_chg = nxt_b != b_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
      i_ff <= 1'b0;
    end else begin
      a_ff <= nxt_a;
      b_ff <= nxt_b;
      i_ff <= (i_sync_ff[1] == i_sync_ff[2]) ? i_sync_ff[2] : i_ff;
    end
  end

  // ****************************************************************
  // direction and count pulses
  // ****************************************************************
  // a leads b: a edge sees b differ after rise -> forward
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      up_ff <= 1'b1;
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= 1'b0;
      if (a_chg && !b_chg) begin
        up_ff <= nxt_a ^ b_ff;
        pulse_ff <= 1'b1;
      end else if (b_chg && !a_chg) begin
        up_ff <= ~(nxt_b ^ a_ff);
        pulse_ff <= x4_mode;
      end
    end
  end

  assign enc.cnt_pulse = pulse_ff;
  assign enc.up = up_ff;
  assign enc.a_lvl = a_ff;
  assign enc.b_lvl = b_ff;
  assign enc.idx_lvl = i_ff;
endmodule
`default_nettype wire

// *** core/qpc_top.sv ***
// Purpose: quadrature position counter with index reset and count error check
// Assumes: Avalon-MM slave, one wait state on every access
// Notes: interrupt is level, high while an unmasked sticky flag is set
// How it works
// - a leading b means forward, a lagging b means reverse
// - sixteen bit counter steps one per count pulse in modes 100 to 111, direction picks up or down
// - error checking only in index reset modes 110 and 100
// - count hitting ffff or max plus one sets error bit 15 and interrupt
// - disable bit 8 of filter control blocks the count error interrupt
// - after error counting continues, natural wrap gives no interrupt
// - error flag readable and writable, set by hardware, cleared by software
// - index reset enable bit 2 works only in modes 100 and 110
// - with index reset off the count wraps only at its limits
// - index reset needs phase states to match the two match bits
// - 4x mode: upper bit is phase b state, lower is phase a
// - 2x mode: upper bit picks phase, lower gives its state
// - index reset modes interrupt on index, not on wrap
// - direction drives an output pin and reads at control bit 11
`timescale 1ns/1ps
`default_nettype none
module qpc_top
  import qpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_pulse_input,
  output logic count_direction,
  output logic irq,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  qpc_enc_if enc();

  logic [2:0] mode_ff;
  logic idx_rst_en_ff;
  logic idx_irq_msk_ff;
  logic idx_flag_ff;
  logic err_flag_ff;
  logic count_error_interrupt_disable_ff;
  logic [1:0] imv_ff;
  logic [15:0] pos_ff;
  logic [15:0] max_ff;
  logic ack_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic dir_ff;
  logic idx_prev_ff;
  logic x4;
  logic idx_mode;
  logic max_mode;
  logic idx_rise;
  logic idx_match;
  logic [15:0] nxt_pos;
  logic err_hit;
  logic wr_ctrl, wr_filt, wr_pos, wr_max;
  logic [31:0] rd_mux;

  qpc_decoder u_dec (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .phase_a_input(phase_a_input),
    .phase_b_input(phase_b_input),
    .index_pulse_input(index_pulse_input),
    .x4_mode(x4),
    .enc(enc)
  );

  // ****************************************************************
  // mode decode
  // ****************************************************************
  assign x4 = mode_ff[1];
  assign idx_mode = (mode_ff == QPC_MODE_X4_IDX) || (mode_ff == QPC_MODE_X2_IDX);
  assign max_mode = (mode_ff == QPC_MODE_X4_MAX) || (mode_ff == QPC_MODE_X2_MAX);
  assign idx_rise = enc.idx_lvl && !idx_prev_ff;

  // phase condition qualifying the index
  always_comb begin
    if (x4) begin
      idx_match = (enc.b_lvl == imv_ff[1]) && (enc.a_lvl == imv_ff[0]);
    end else begin
      idx_match = (imv_ff[1] ? enc.b_lvl : enc.a_lvl) == imv_ff[0];
    end
  end

  // ****************************************************************
  // position counter
  // ****************************************************************
  always_comb begin
    nxt_pos = pos_ff;
    err_hit = 1'b0;
    if (enc.cnt_pulse && (idx_mode || max_mode)) begin
      if (enc.up) begin
        if (max_mode && pos_ff == max_ff) begin
          nxt_pos = QPC_POS_RST;
        end else begin
          nxt_pos = pos_ff + 16'h0001;
        end
      end else begin
        if (max_mode && pos_ff == QPC_POS_RST) begin
          nxt_pos = max_ff;
        end else begin
          nxt_pos = pos_ff - 16'h0001;
        end
      end
      // error: count reaches ffff going down or max+1 going up
      if (idx_mode) begin
        err_hit = enc.up ? (nxt_pos == max_ff + 16'h0001) : (nxt_pos == QPC_ERR_CMP);
      end
    end
    if (idx_mode && idx_rst_en_ff && idx_rise && idx_match) begin
      nxt_pos = QPC_POS_RST;
      err_hit = 1'b0;
    end
  end

  assign wr_ctrl = avs_write && ack_ff && avs_address == QPC_OFF_CTRL;
  assign wr_filt = avs_write && ack_ff && avs_address == QPC_OFF_FILT;
  assign wr_pos = avs_write && ack_ff && avs_address == QPC_OFF_POS;
  assign wr_max = avs_write && ack_ff && avs_address == QPC_OFF_MAX;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pos_ff <= QPC_POS_RST;
      idx_prev_ff <= 1'b0;
    end else begin
      idx_prev_ff <= enc.idx_lvl;
      if (wr_pos && avs_byteenable[1:0] == 2'h3) begin
        pos_ff <= avs_writedata[15:0];
      end else begin
        pos_ff <= nxt_pos;
      end
    end
  end

  // ****************************************************************
  // sticky flags: set wins over software clear
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      err_flag_ff <= 1'b0;
      idx_flag_ff <= 1'b0;
    end else begin
      if (err_hit) begin
        err_flag_ff <= 1'b1;
      end else if (wr_ctrl && avs_byteenable[1] && avs_writedata[QPC_CTRL_ERR_BIT]) begin
        err_flag_ff <= 1'b0;
      end
      if (idx_mode && idx_rise && idx_match) begin
        idx_flag_ff <= 1'b1;
      end else if (wr_ctrl && avs_byteenable[0] && avs_writedata[QPC_CTRL_IDXIRQ_BIT]) begin
        idx_flag_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_ff <= QPC_MODE_OFF;
      idx_rst_en_ff <= 1'b0;
      idx_irq_msk_ff <= 1'b0;
      count_error_interrupt_disable_ff <= 1'b0;
      imv_ff <= 2'h0;
      max_ff <= QPC_MAX_RST;
    end else begin
      if (wr_ctrl && avs_byteenable[0]) begin
        idx_rst_en_ff <= avs_writedata[QPC_CTRL_IDXRST_BIT];
        idx_irq_msk_ff <= avs_writedata[QPC_CTRL_IDXMSK_BIT];
      end
      if (wr_ctrl && avs_byteenable[1]) begin
        mode_ff <= avs_writedata[QPC_CTRL_MODE_LO +: 3];
      end
      if (wr_filt && avs_byteenable[1]) begin
        count_error_interrupt_disable_ff <= avs_writedata[QPC_FILT_COUNT_ERROR_INTERRUPT_DISABLE_BIT];
        imv_ff <= avs_writedata[QPC_FILT_IMV_LO +: 2];
      end
      if (wr_max && avs_byteenable[1:0] == 2'h3) begin
        max_ff <= avs_writedata[15:0];
      end
    end
  end

  // ****************************************************************
  // bus slave: one wait state, unmapped reads return zero
  // ****************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      QPC_OFF_CTRL: begin
        rd_mux[QPC_CTRL_ERR_BIT] = err_flag_ff;
        rd_mux[QPC_CTRL_DIR_BIT] = enc.up;
        rd_mux[QPC_CTRL_MODE_LO +: 3] = mode_ff;
        rd_mux[QPC_CTRL_IDXRST_BIT] = idx_rst_en_ff;
        rd_mux[QPC_CTRL_IDXIRQ_BIT] = idx_flag_ff;
        rd_mux[QPC_CTRL_IDXMSK_BIT] = idx_irq_msk_ff;
      end
      QPC_OFF_FILT: begin
        rd_mux[QPC_FILT_COUNT_ERROR_INTERRUPT_DISABLE_BIT] = count_error_interrupt_disable_ff;
        rd_mux[QPC_FILT_IMV_LO +: 2] = imv_ff;
      end
      QPC_OFF_POS: rd_mux[15:0] = pos_ff;
      QPC_OFF_MAX: rd_mux[15:0] = max_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
      // registered copy of the inverse, so the pin comes straight from a flop
      wait_ff <= !((avs_read || avs_write) && !ack_ff);
      if (avs_read && !ack_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
      dir_ff <= 1'b1;
    end else begin
      irq_ff <= (err_flag_ff && !count_error_interrupt_disable_ff) || (idx_flag_ff && !idx_irq_msk_ff);
      dir_ff <= enc.up;
    end
  end

  assign irq = irq_ff;
  assign count_direction = dir_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_err_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    err_hit |=> err_flag_ff) else $error("error hit did not set flag");
  chk_err_mode_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !idx_mode |-> !err_hit) else $error("error check outside index modes");
  chk_count_error_interrupt_disable_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (count_error_interrupt_disable_ff && !idx_flag_ff) |=> !irq_ff) else $error("irq despite disable");
  chk_err_irq_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (err_flag_ff && !count_error_interrupt_disable_ff) |=> irq_ff) else $error("error irq missing");
  chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (err_flag_ff && !wr_ctrl) |=> err_flag_ff) else $error("error flag dropped");
  chk_idx_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (idx_mode && idx_rst_en_ff && idx_rise && idx_match && !wr_pos) |=> pos_ff == 16'h0000)
    else $error("index did not clear count");
  chk_no_idx_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!idx_rst_en_ff && !enc.cnt_pulse && !wr_pos) |=> $stable(pos_ff))
    else $error("count changed without pulse");
  chk_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (idx_mode && enc.cnt_pulse && enc.up && !idx_rise && !wr_pos) |=> pos_ff == $past(pos_ff) + 16'h0001)
    else $error("up count wrong");
  chk_dir_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> count_direction == $past(enc.up)) else $error("direction pin lags");
  chk_bus_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($rose(avs_read) && !ack_ff) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered in one wait");
  cov_err: cover property (@(posedge ref_clk) disable iff (!rst_n) err_hit);
  cov_idx_rst: cover property (@(posedge ref_clk) disable iff (!rst_n)
    idx_mode && idx_rst_en_ff && idx_rise && idx_match);
  cov_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq_ff));
  cov_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
    max_mode && enc.cnt_pulse && pos_ff == max_ff);
endmodule
`default_nettype wire

// *** tb/qpc_encoder_model.sv ***
// Purpose: behavioural incremental shaft encoder with index output
// Assumes: shaft starts at rest with both phases low
// Notes: outputs change only just after a rising ref_clk edge
`timescale 1ns/1ps
`default_nettype none
module qpc_encoder_model (
  input wire logic ref_clk,
  output logic phase_a,
  output logic phase_b,
  output logic index
);
  logic [1:0] ph = 2'h0;
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    index = 1'b0;
  end
  // ****************************************************************
  // motion and index
  // ****************************************************************
  // gap sets shaft speed: small gives prompt edges, large a slow shaft
  task automatic move(input bit fwd, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge ref_clk);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      phase_a <= (ph == 2'h1) || (ph == 2'h2);
      phase_b <= ph[1];
    end
  endtask
  // index only where both phases sit low, as a real disc does
  task automatic pulse(input int len);
    @(posedge ref_clk);
    if (ph == 2'h0) begin
      index <= 1'b1;
      repeat (len) @(posedge ref_clk);
      index <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** tb/qpc_top_bench.sv ***
// Purpose: self-checking bench for the quadrature position counter
// Assumes: one wait state per register access, encoder model on the pins
// Notes: byteenable stays all ones; every access is a full word
`timescale 1ns/1ps
`default_nettype none
module qpc_top_bench import qpc_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n, a_w, b_w, idx_w, dir, irq, rd_s, wr_s, waitreq;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  int error_cnt = 0;
  int num_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  // encoder pins are taken as plain digital inputs here
  qpc_encoder_model qpc_encoder_model_inst (.ref_clk(ref_clk), .phase_a(a_w), .phase_b(b_w),
    .index(idx_w));
  qpc_top qpc_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .phase_a_input(a_w),
    .phase_b_input(b_w), .index_pulse_input(idx_w), .count_direction(dir), .irq(irq),
    .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdata),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(waitreq));
  // ****************************************************************
  // checking and bus access
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s is %h, wanted %h", $time, what, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    bit done;
    done = 1'b0;
    q = 32'h0;
    @(posedge ref_clk);
    addr <= a;
    wr_s <= w;
    rd_s <= !w;
    wdata <= d;
    // waitrequest and readdata are taken at the rising edge, before flops update
    for (int n = 0; n < 16 && !done; n++) begin
      @(posedge ref_clk);
      if (waitreq === 1'b0) begin
        done = 1'b1;
        q = rdata;
      end
    end
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    if (!done) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp, what);
  endtask
  task automatic pins(input logic [1:0] exp);
    // irq is registered behind the flags and masks: let it settle first
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({30'h0, dir, irq}, {30'h0, exp}, "dir and irq");
  endtask
  task automatic mv(input bit fwd, input int n, input int gap);
    qpc_encoder_model_inst.move(fwd, n, gap);
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic idx();
    qpc_encoder_model_inst.pulse(6);
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, error_cnt);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    rd_s = 1'b0;
    wr_s = 1'b0;
    wdata = 32'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(QPC_OFF_CTRL, 32'h0000_0800, "ctrl");
    rd(QPC_OFF_FILT, 32'h0000_0000, "filt");
    rd(QPC_OFF_POS, {16'h0, QPC_POS_RST}, "pos");
    rd(QPC_OFF_MAX, {16'h0, QPC_MAX_RST}, "max");
    rd(4'h1, 32'h0000_0000, "unmapped");
    pins(2'b10);
    end_test("reset");
    wr(QPC_OFF_MAX, 32'h0000_0010);
    wr(QPC_OFF_CTRL, 32'h0000_0700);
    mv(1'b1, 4, 8);
    rd(QPC_OFF_POS, 32'h0000_0004, "pos up");
    mv(1'b0, 6, 5);
    rd(QPC_OFF_POS, 32'h0000_000f, "pos wrap");
    rd(QPC_OFF_CTRL, 32'h0000_0700, "ctrl wrap");
    pins(2'b00);
    mv(1'b0, 2, 8);
    end_test("count");
    wr(QPC_OFF_CTRL, 32'h0000_0600);
    wr(QPC_OFF_POS, 32'h0000_000f);
    mv(1'b1, 2, 8);
    rd(QPC_OFF_CTRL, 32'h0000_8e00, "ctrl err up");
    pins(2'b11);
    mv(1'b1, 2, 8);
    rd(QPC_OFF_POS, 32'h0000_0013, "pos after err");
    rd(QPC_OFF_CTRL, 32'h0000_8e00, "ctrl err kept");
    wr(QPC_OFF_CTRL, 32'h0000_8600);
    rd(QPC_OFF_CTRL, 32'h0000_0e00, "ctrl err clear");
    pins(2'b10);
    wr(QPC_OFF_FILT, 32'h0000_0100);
    wr(QPC_OFF_POS, 32'h0000_0000);
    mv(1'b0, 1, 8);
    rd(QPC_OFF_CTRL, 32'h0000_8600, "ctrl err down");
    pins(2'b00);
    rd(QPC_OFF_POS, 32'h0000_ffff, "pos down");
    wr(QPC_OFF_CTRL, 32'h0000_8600);
    mv(1'b1, 1, 8);
    end_test("count error");
    wr(QPC_OFF_FILT, 32'h0000_0000);
    wr(QPC_OFF_CTRL, 32'h0000_0604);
    wr(QPC_OFF_POS, 32'h0000_0005);
    idx();
    rd(QPC_OFF_POS, 32'h0000_0000, "pos index");
    rd(QPC_OFF_CTRL, 32'h0000_0e06, "ctrl index");
    pins(2'b11);
    wr(QPC_OFF_CTRL, 32'h0000_0605);
    pins(2'b10);
    wr(QPC_OFF_CTRL, 32'h0000_0606);
    rd(QPC_OFF_CTRL, 32'h0000_0e04, "ctrl flag clear");
    pins(2'b10);
    wr(QPC_OFF_FILT, 32'h0000_0600);
    wr(QPC_OFF_POS, 32'h0000_0005);
    idx();
    rd(QPC_OFF_POS, 32'h0000_0005, "pos no match");
    wr(QPC_OFF_CTRL, 32'h0000_0602);
    wr(QPC_OFF_FILT, 32'h0000_0000);
    idx();
    rd(QPC_OFF_POS, 32'h0000_0005, "pos reset off");
    wr(QPC_OFF_CTRL, 32'h0000_0706);
    idx();
    rd(QPC_OFF_POS, 32'h0000_0005, "pos max mode");
    end_test("index 4x");
    wr(QPC_OFF_CTRL, 32'h0000_0406);
    wr(QPC_OFF_POS, 32'h0000_0000);
    mv(1'b1, 4, 8);
    rd(QPC_OFF_POS, 32'h0000_0002, "pos 2x");
    wr(QPC_OFF_FILT, 32'h0000_0200);
    idx();
    rd(QPC_OFF_POS, 32'h0000_0002, "pos 2x no match");
    wr(QPC_OFF_FILT, 32'h0000_0400);
    idx();
    rd(QPC_OFF_POS, 32'h0000_0000, "pos 2x match");
    end_test("index 2x");
    final_report();
  end
endmodule
`default_nettype wire
